//--- pkg/ccp_pkg.sv
// Constants and types for the CC role and VBUS power control block
`default_nettype none
package ccp_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_ROLE = 8'h1a;
  localparam logic [7:0] ADDR_FAULT = 8'h1b;
  localparam logic [7:0] ADDR_POWER = 8'h1c;
  localparam logic [7:0] ADDR_STATUS = 8'h1d;
  // Reset values and writable masks
  localparam logic [7:0] ROLE_RST_NOVDD = 8'h0f;
  localparam logic [7:0] ROLE_RST_VDD = 8'h05;
  localparam logic [7:0] FAULT_RST = 8'h00;
  localparam logic [7:0] POWER_RST = 8'h60;
  localparam logic [7:0] ROLE_MASK = 8'h7f;
  localparam logic [7:0] FAULT_MASK = 8'h09;
  localparam logic [7:0] POWER_MASK = 8'h7f;
  // Role control fields
  localparam int ROLE_DUAL = 6;
  localparam int ROLE_RP_HI = 5;
  localparam int ROLE_RP_LO = 4;
  localparam int ROLE_CC2_HI = 3;
  localparam int ROLE_CC2_LO = 2;
  localparam int ROLE_CC1_HI = 1;
  localparam int ROLE_CC1_LO = 0;
  // Fault control fields
  localparam int FAULT_TIMER_OFF = 3;
  localparam int FAULT_OCP_OFF = 0;
  // Power control fields
  localparam int PWR_MON_OFF = 6;
  localparam int PWR_ALARM_OFF = 5;
  localparam int PWR_DISCHARGE_ON_DISCONNECT = 4;
  localparam int PWR_BLEED = 3;
  localparam int PWR_FORCE = 2;
  localparam int PWR_VCONN = 0;
  // Status fields
  localparam int STAT_SEARCH = 5;
  localparam int STAT_RES_RD = 4;
  // Termination codes
  localparam logic [1:0] TERM_RA = 2'h0;
  localparam logic [1:0] TERM_RP = 2'h1;
  localparam logic [1:0] TERM_RD = 2'h2;
  localparam logic [1:0] TERM_OPEN = 2'h3;
  // Timing
  localparam int CLK_KHZ = 25000;
  localparam int TOG_HALF_US = 50;
  localparam int TOG_HALF_CYC = TOG_HALF_US * CLK_KHZ / 1000;
  localparam int TOG_SETTLE_CYC = 4;
  localparam int DISCH_TIMEOUT_US = 1000;
  localparam int DISCH_TIMEOUT_CYC = DISCH_TIMEOUT_US * CLK_KHZ / 1000;
  localparam int STRAP_CYC = 2;
  // Pin bundle layout
  localparam int PIN_W = 19;
  localparam int PIN_VDD = 18;
  localparam int PIN_DISC = 17;
  localparam int PIN_SAFE0 = 16;
  localparam int PIN_AHI = 15;
  localparam int PIN_ALO = 14;
  localparam int PIN_CC2 = 12;
  localparam int PIN_CC1 = 10;
  localparam int PIN_VBUS = 0;
  typedef enum logic [1:0] {
    DS_IDLE = 2'b00,
    DS_SRC_OFF = 2'b01,
    DS_AUTO = 2'b10
  } ccp_dis_t;
  typedef enum logic [1:0] {
    TG_IDLE = 2'b00,
    TG_SEARCH = 2'b01,
    TG_RESOLVED = 2'b10
  } ccp_tog_t;
endpackage : ccp_pkg
`default_nettype wire

//--- pkg/ccp_tog_if.sv
// Carrier between the register bank and the toggle engine
`timescale 1ns/10ps
`default_nettype none
interface ccp_tog_if;
  logic start;
  logic start_rd;
  logic abort;
  logic seen;
  logic searching;
  logic resolved;
  logic present_rd;
  modport ctl (output start, start_rd, abort, seen,
               input searching, resolved, present_rd);
  modport tog (input start, start_rd, abort, seen,
               output searching, resolved, present_rd);
endinterface : ccp_tog_if
`default_nettype wire

//--- rtl/ccp_toggle.sv
// Dual-role toggle engine: alternates Rp and Rd until a partner shows up
`timescale 1ns/10ps
`default_nettype none
module ccp_toggle (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Link to the register bank
  ccp_tog_if.tog tg
);
  typedef struct packed {
    ccp_pkg::ccp_tog_t mode;
    logic present_rd;
    logic [15:0] cnt;
  } ccp_tst_t;

  ccp_tst_t st;
  ccp_tst_t next_st;
  logic settled;

  ////////////////////////////////////////////////////////////////////////////
  // Stale comparator codes from the last half period are ignored
  assign settled = st.cnt >= 16'(ccp_pkg::TOG_SETTLE_CYC);

  always_comb begin
    next_st = st;
    case (st.mode)
      ccp_pkg::TG_IDLE: begin
        next_st.cnt = '0;
      end
      ccp_pkg::TG_SEARCH: begin
        if (tg.seen && settled) begin
          next_st.mode = ccp_pkg::TG_RESOLVED;
        end else if (st.cnt == 16'(ccp_pkg::TOG_HALF_CYC - 1)) begin
          next_st.present_rd = !st.present_rd;
          next_st.cnt = '0;
        end else begin
          next_st.cnt = st.cnt + 16'h0001;
        end
      end
      ccp_pkg::TG_RESOLVED: begin
        next_st.cnt = '0;
      end
      default: begin
        next_st.mode = ccp_pkg::TG_IDLE;
      end
    endcase
    if (tg.abort) begin
      next_st.mode = ccp_pkg::TG_IDLE;
    end
    if (tg.start) begin
      next_st.mode = ccp_pkg::TG_SEARCH;
      next_st.present_rd = tg.start_rd;
      next_st.cnt = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st <= '{mode: ccp_pkg::TG_IDLE, present_rd: 1'b0, cnt: 16'h0000};
    end else begin
      st <= next_st;
    end
  end

  assign tg.searching = st.mode == ccp_pkg::TG_SEARCH;
  assign tg.resolved = st.mode == ccp_pkg::TG_RESOLVED;
  assign tg.present_rd = st.present_rd;

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_found;
    tg.searching && tg.seen && settled && !tg.start && !tg.abort
      |=> !tg.searching && tg.resolved;
  endproperty
  a_found: assert property (p_found) else $error("search not ended");

  property p_hold;
    tg.resolved && !tg.start && !tg.abort
      |=> tg.resolved && $stable(tg.present_rd);
  endproperty
  a_hold: assert property (p_hold) else $error("resolution lost");

  property p_alternate;
    tg.searching && !tg.seen && !tg.start && !tg.abort
      && st.cnt == 16'(ccp_pkg::TOG_HALF_CYC - 1)
      |=> tg.searching && (tg.present_rd != $past(tg.present_rd));
  endproperty
  a_alternate: assert property (p_alternate) else $error("no toggle");
endmodule : ccp_toggle
`default_nettype wire

//--- rtl/ccp_ctrl.sv
// CC role, fault and VBUS power control register bank
//
// Overview of operation
// - Dual-role clear: apply the two termination fields
// - Rp current level from bits 5:4 always
// - Termination fields select Ra, Rp, Rd, Open
// - Look command alternates terminations until connection
// - Connection resolves Rp or Rd and holds it
// - Both open, not dual-role: PHY powers down
// - Toggle only from Rp/Rp or Rd/Rd, else ignore
// - Fault bit 3 set disables discharge timer
// - Fault bit 0 set disables cable power overcurrent
// - Monitor off: voltage readings read zero
// - Power bit 5 suppresses voltage alarm reports
// - Source auto discharge: stop sourcing, then discharge
// - Sourcing off no later than discharge start
// - Sink auto discharge on disconnect
// - Auto discharge ends below safe zero volts
// - Power bit 3 enables bleed discharge load
// - Power bit 2 forces discharge while set, until the discharge timer expires
// - Power bit 1 stored, no function
// - Power bit 0 connects cable power source
// - Role reset 0x0f, or 0x05 with VDD
// - Flip select picks cable power pin
// - Search flag high while toggling, falls on find
`timescale 1ns/10ps
`default_nettype none
module ccp_ctrl #(
  parameter int DISCH_TIMEOUT_CYC = ccp_pkg::DISCH_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port from the serial front end
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Commands and controls from the same clock domain
  input wire logic cmd_connection_search,
  input wire logic plug_flip_select,
  input wire logic src_vbus_req,
  // Asynchronous pins and analog results
  input wire logic vdd_present,
  input wire logic vbus_disconnect,
  input wire logic vbus_below_safe0v,
  input wire logic alarm_hi_in,
  input wire logic alarm_lo_in,
  input wire logic [1:0] cc1_seen,
  input wire logic [1:0] cc2_seen,
  input wire logic [9:0] vbus_level,
  // CC line controls
  output logic [1:0] cc1_termination,
  output logic [1:0] cc2_termination,
  output logic [1:0] pullup_current_level,
  output logic phy_power_down,
  // Cable power controls
  output logic vconn_cc1_en,
  output logic vconn_cc2_en,
  output logic cable_power_overcurrent_en,
  // VBUS controls and reports
  output logic vbus_source_en,
  output logic vbus_discharge_en,
  output logic bleed_discharge_en,
  output logic discharge_timer_en,
  output logic discharge_failed,
  output logic [9:0] vbus_voltage,
  output logic alarm_hi,
  output logic alarm_lo
);
  typedef struct packed {
    logic [7:0] role;
    logic [7:0] fault;
    logic [7:0] power;
    logic [7:0] rdata;
    logic [ccp_pkg::PIN_W-1:0] s1;
    logic [ccp_pkg::PIN_W-1:0] s2;
    logic [1:0] strap;
    ccp_pkg::ccp_dis_t ds;
    logic src_cut;
    logic [15:0] dcnt;
    logic forced_expired;
    logic failed;
    logic disc_prev;
    logic [9:0] vbus;
    logic ahi;
    logic alo;
  } ccp_cst_t;

  ccp_cst_t st;
  ccp_cst_t next_st;
  ccp_tog_if tg ();

  // Status view of one CC pin from its applied termination
  function automatic logic [1:0] pin_status(input logic [1:0] term,
                                            input logic [1:0] seen);
    pin_status = (term == ccp_pkg::TERM_RP || term == ccp_pkg::TERM_RD)
                 ? seen : 2'h0;
  endfunction : pin_status

  ccp_toggle u_toggle (
    .clk(clk),
    .nrst(nrst),
    .tg(tg.tog)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Derived state
  logic [1:0] cc1_field;
  logic [1:0] cc2_field;
  logic dual;
  logic use_tog;
  logic [1:0] tog_term;
  logic [1:0] s_cc1;
  logic [1:0] s_cc2;
  logic is_source;
  logic disc_edge;
  logic forced_active;
  logic disch_active;
  logic timer_on;
  logic expired;
  logic [7:0] status;
  logic hide_cc;
  logic acceptable;

  assign cc1_field = st.role[ccp_pkg::ROLE_CC1_HI:ccp_pkg::ROLE_CC1_LO];
  assign cc2_field = st.role[ccp_pkg::ROLE_CC2_HI:ccp_pkg::ROLE_CC2_LO];
  assign dual = st.role[ccp_pkg::ROLE_DUAL];
  assign use_tog = dual && (tg.searching || tg.resolved);
  assign tog_term = tg.present_rd ? ccp_pkg::TERM_RD : ccp_pkg::TERM_RP;
  assign s_cc1 = st.s2[ccp_pkg::PIN_CC1 +: 2];
  assign s_cc2 = st.s2[ccp_pkg::PIN_CC2 +: 2];
  assign is_source = (cc1_termination == ccp_pkg::TERM_RP)
                     || (cc2_termination == ccp_pkg::TERM_RP);
  assign disc_edge = st.s2[ccp_pkg::PIN_DISC] && !st.disc_prev;
  assign forced_active = st.power[ccp_pkg::PWR_FORCE] && !st.forced_expired;
  assign disch_active = st.ds == ccp_pkg::DS_AUTO || forced_active;
  assign timer_on = !st.fault[ccp_pkg::FAULT_TIMER_OFF];
  assign expired = timer_on
                   && st.dcnt >= 16'(DISCH_TIMEOUT_CYC - 1);
  assign acceptable = dual && cc1_field == cc2_field
                      && (cc1_field == ccp_pkg::TERM_RP
                          || cc1_field == ccp_pkg::TERM_RD);

  ////////////////////////////////////////////////////////////////////////////
  // Toggle engine hookup
  assign tg.start = cmd_connection_search && acceptable;
  assign tg.start_rd = cc1_field == ccp_pkg::TERM_RD;
  assign tg.abort = reg_wr && reg_addr == ccp_pkg::ADDR_ROLE;
  assign tg.seen = tg.present_rd
                   ? (s_cc1 != 2'h0 || s_cc2 != 2'h0)
                   : (s_cc1 == ccp_pkg::TERM_RD || s_cc2 == ccp_pkg::TERM_RD);

  ////////////////////////////////////////////////////////////////////////////
  // Line status
  assign hide_cc = tg.searching
                   || (st.power[ccp_pkg::PWR_VCONN] && !plug_flip_select);
  always_comb begin
    status = 8'h00;
    status[ccp_pkg::STAT_SEARCH] = tg.searching;
    status[ccp_pkg::STAT_RES_RD] = tg.resolved && tg.present_rd;
    if (!hide_cc) begin
      status[3:2] = pin_status(cc2_termination, s_cc2);
      status[1:0] = pin_status(cc1_termination, s_cc1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_st = st;
    next_st.s1 = {vdd_present, vbus_disconnect, vbus_below_safe0v,
                  alarm_hi_in, alarm_lo_in, cc2_seen, cc1_seen, vbus_level};
    next_st.s2 = st.s1;
    next_st.disc_prev = st.s2[ccp_pkg::PIN_DISC];
    if (st.strap != 2'h3) begin
      next_st.strap = st.strap + 2'h1;
    end
    if (st.strap == 2'(ccp_pkg::STRAP_CYC) && st.s2[ccp_pkg::PIN_VDD]) begin
      next_st.role = ccp_pkg::ROLE_RST_VDD;
    end
    if (reg_wr) begin
      case (reg_addr)
        ccp_pkg::ADDR_ROLE: next_st.role = reg_wdata & ccp_pkg::ROLE_MASK;
        ccp_pkg::ADDR_FAULT: next_st.fault = reg_wdata & ccp_pkg::FAULT_MASK;
        ccp_pkg::ADDR_POWER: next_st.power = reg_wdata & ccp_pkg::POWER_MASK;
        default: next_st.role = next_st.role;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        ccp_pkg::ADDR_ROLE: next_st.rdata = st.role;
        ccp_pkg::ADDR_FAULT: next_st.rdata = st.fault;
        ccp_pkg::ADDR_POWER: next_st.rdata = st.power;
        ccp_pkg::ADDR_STATUS: next_st.rdata = status;
        default: next_st.rdata = 8'h00;
      endcase
    end
    // Measurement and alarm reporting
    next_st.vbus = st.power[ccp_pkg::PWR_MON_OFF]
                   ? 10'h000 : st.s2[ccp_pkg::PIN_VBUS +: 10];
    next_st.ahi = st.s2[ccp_pkg::PIN_AHI]
                  && !st.power[ccp_pkg::PWR_ALARM_OFF];
    next_st.alo = st.s2[ccp_pkg::PIN_ALO]
                  && !st.power[ccp_pkg::PWR_ALARM_OFF];
    // Discharge timer, shared by auto and forced discharge
    next_st.dcnt = (disch_active && timer_on) ? st.dcnt + 16'h0001 : '0;
    if (!src_vbus_req) begin
      next_st.src_cut = 1'b0;
    end
    case (st.ds)
      ccp_pkg::DS_IDLE: begin
        if (disc_edge && st.power[ccp_pkg::PWR_DISCHARGE_ON_DISCONNECT]) begin
          next_st.failed = 1'b0;
          if (is_source) begin
            next_st.src_cut = 1'b1;
            next_st.ds = ccp_pkg::DS_SRC_OFF;
          end else begin
            next_st.ds = ccp_pkg::DS_AUTO;
          end
        end
      end
      ccp_pkg::DS_SRC_OFF: begin
        next_st.ds = ccp_pkg::DS_AUTO;
      end
      ccp_pkg::DS_AUTO: begin
        if (st.s2[ccp_pkg::PIN_SAFE0]) begin
          next_st.ds = ccp_pkg::DS_IDLE;
        end else if (expired) begin
          next_st.ds = ccp_pkg::DS_IDLE;
          next_st.failed = 1'b1;
        end
      end
      default: begin
        next_st.ds = ccp_pkg::DS_IDLE;
      end
    endcase
    if (!st.power[ccp_pkg::PWR_FORCE]) begin
      next_st.forced_expired = 1'b0;
    end else if (forced_active && expired) begin
      next_st.forced_expired = 1'b1;
      next_st.failed = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st <= '0;
      st.role <= ccp_pkg::ROLE_RST_NOVDD;
      st.fault <= ccp_pkg::FAULT_RST;
      st.power <= ccp_pkg::POWER_RST;
      st.ds <= ccp_pkg::DS_IDLE;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign cc1_termination = use_tog ? tog_term : cc1_field;
  assign cc2_termination = use_tog ? tog_term : cc2_field;
  assign pullup_current_level =
    st.role[ccp_pkg::ROLE_RP_HI:ccp_pkg::ROLE_RP_LO];
  assign phy_power_down = !dual && cc1_field == ccp_pkg::TERM_OPEN
                          && cc2_field == ccp_pkg::TERM_OPEN;
  assign vconn_cc2_en = st.power[ccp_pkg::PWR_VCONN]
                        && !plug_flip_select;
  assign vconn_cc1_en = st.power[ccp_pkg::PWR_VCONN]
                        && plug_flip_select;
  assign cable_power_overcurrent_en =
    !st.fault[ccp_pkg::FAULT_OCP_OFF];
  assign vbus_source_en = src_vbus_req && !st.src_cut
                          && !disch_active;
  assign vbus_discharge_en = disch_active;
  assign bleed_discharge_en = st.power[ccp_pkg::PWR_BLEED];
  assign discharge_timer_en = timer_on;
  assign discharge_failed = st.failed;
  assign vbus_voltage = st.vbus;
  assign alarm_hi = st.ahi;
  assign alarm_lo = st.alo;
  assign reg_rdata = st.rdata;

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_ignore;
    cmd_connection_search && !acceptable && !tg.searching
      |=> !tg.searching;
  endproperty
  a_ignore: assert property (p_ignore) else $error("bad command taken");

  sequence s_src_disc;
    st.ds == ccp_pkg::DS_IDLE && disc_edge && !forced_active && !reg_wr
      && st.power[ccp_pkg::PWR_DISCHARGE_ON_DISCONNECT] && is_source;
  endsequence
  sequence s_cut_then_drain;
    !vbus_source_en && !vbus_discharge_en ##1 vbus_discharge_en;
  endsequence
  property p_src_order;
    s_src_disc |=> s_cut_then_drain;
  endproperty
  a_src_order: assert property (p_src_order) else $error("bad order");

  property p_no_late_cut;
    $rose(vbus_discharge_en) |-> !vbus_source_en;
  endproperty
  a_no_late_cut: assert property (p_no_late_cut) else $error("source on");

  property p_sink_disc;
    st.ds == ccp_pkg::DS_IDLE && disc_edge
      && st.power[ccp_pkg::PWR_DISCHARGE_ON_DISCONNECT] && !is_source
      |=> vbus_discharge_en;
  endproperty
  a_sink_disc: assert property (p_sink_disc) else $error("no sink drain");

  property p_auto_end;
    st.ds == ccp_pkg::DS_AUTO && st.s2[ccp_pkg::PIN_SAFE0]
      |=> st.ds == ccp_pkg::DS_IDLE;
  endproperty
  a_auto_end: assert property (p_auto_end) else $error("drain not ended");

  property p_mon_off;
    st.power[ccp_pkg::PWR_MON_OFF] |=> vbus_voltage == 10'h000;
  endproperty
  a_mon_off: assert property (p_mon_off) else $error("reading not zero");

  property p_alarm_off;
    st.power[ccp_pkg::PWR_ALARM_OFF] |=> !alarm_hi && !alarm_lo;
  endproperty
  a_alarm_off: assert property (p_alarm_off) else $error("alarm shown");

  property p_reserved;
    reg_wr && reg_addr == ccp_pkg::ADDR_FAULT
      |=> (st.fault & ~ccp_pkg::FAULT_MASK) == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved set");

  property p_timer_off;
    st.fault[ccp_pkg::FAULT_TIMER_OFF] && forced_active
      && st.power[ccp_pkg::PWR_FORCE] && !reg_wr |=> forced_active;
  endproperty
  a_timer_off: assert property (p_timer_off) else $error("timer ran");
endmodule : ccp_ctrl
`default_nettype wire

//--- testbench/ccp_partner.sv
// Port partner model on the CC wires and VBUS
`timescale 1ns/10ps
`default_nettype none
module ccp_partner (
  // Clock
  input wire logic clk,
  // Device side
  input wire logic [1:0] cc_pin1_termination,
  input wire logic dis_en,
  // Scenario: 0 absent, 1 sink, 2 source; slow VBUS decay
  input wire logic [1:0] mode,
  input wire logic slow,
  // Partner outputs
  output logic [1:0] cc1_seen,
  output logic [1:0] cc2_seen,
  output logic vbus_disconnect,
  output logic vbus_below_safe0v
);
  int cnt = 0;
  // Sink shows Rd to an Rp, source shows Rp to an Rd
  always_comb begin
    cc1_seen = 2'h0;
    if (mode == 2'h1 && cc_pin1_termination == ccp_pkg::TERM_RP) cc1_seen = 2'h2;
    if (mode == 2'h2 && cc_pin1_termination == ccp_pkg::TERM_RD) cc1_seen = 2'h1;
  end
  assign cc2_seen = 2'h0;
  assign vbus_disconnect = (mode == 2'h0);
  // VBUS decays only while the device discharges it
  always @(posedge clk) begin
    if (mode != 2'h0) cnt <= 0;
    else if (dis_en) cnt <= cnt + 1;
  end
  assign vbus_below_safe0v = (mode == 2'h0) && (cnt >= (slow ? 200 : 3));
endmodule : ccp_partner
`default_nettype wire

//--- testbench/ccp_ctrl_tb_top.sv
// Self-checking bench for the CC role and VBUS power control bank
`timescale 1ns/10ps
`default_nettype none
module ccp_ctrl_tb_top;
  logic clk, rd_taken = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic cmd = 1'b0, flip = 1'b0, src_req = 1'b0, vdd = 1'b0, slow = 1'b0;
  logic ahi_in = 1'b1, alo_in = 1'b0;
  logic [7:0] addr = 8'h0, wdata = 8'h0, rdata, st, v;
  logic [9:0] vlevel = 10'h0, vvolt;
  logic [1:0] pmode = 2'h0, t1, t2, rpl, s1, s2;
  logic pd, vc1, vc2, ocp, src_en, dis_en, bleed, tmr, failed;
  logic ahi, alo, disc, safe0;
  logic [15:0] exp_q[$];
  logic [15:0] e;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  int seed = 32'h4d520f58;
  int ts, td;

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  ccp_ctrl #(.DISCH_TIMEOUT_CYC(50)) u_dut (
    .clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
    .cmd_connection_search(cmd), .plug_flip_select(flip),
    .src_vbus_req(src_req), .vdd_present(vdd),
    .vbus_disconnect(disc), .vbus_below_safe0v(safe0),
    .alarm_hi_in(ahi_in), .alarm_lo_in(alo_in),
    .cc1_seen(s1), .cc2_seen(s2), .vbus_level(vlevel),
    .cc1_termination(t1), .cc2_termination(t2),
    .pullup_current_level(rpl), .phy_power_down(pd),
    .vconn_cc1_en(vc1), .vconn_cc2_en(vc2),
    .cable_power_overcurrent_en(ocp), .vbus_source_en(src_en),
    .vbus_discharge_en(dis_en), .bleed_discharge_en(bleed),
    .discharge_timer_en(tmr), .discharge_failed(failed),
    .vbus_voltage(vvolt), .alarm_hi(ahi), .alarm_lo(alo));

  ccp_partner u_peer (.clk(clk), .cc_pin1_termination(t1), .dis_en(dis_en),
    .mode(pmode), .slow(slow), .cc1_seen(s1), .cc2_seen(s2),
    .vbus_disconnect(disc), .vbus_below_safe0v(safe0));

  //////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [9:0] ex,
                     input logic [9:0] got);
    checks++;
    if (got !== ex) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task automatic chk1(input string nm, input logic ex, input logic got);
    chk(nm, {9'h0, ex}, {9'h0, got});
  endtask : chk1

  task automatic do_reset;
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (5) @(posedge clk);
  endtask : do_reset

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read; a zero mask only fetches the value into st
  task automatic rd(input logic [7:0] a, input logic [7:0] m,
                    input logic [7:0] ex);
    @(posedge clk);
    reg_rd <= 1'b1;
    addr <= a;
    exp_q.push_back({m, ex});
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    st = rdata;
  endtask : rd

  task automatic pulse_cmd;
    @(posedge clk);
    cmd <= 1'b1;
    @(posedge clk);
    cmd <= 1'b0;
  endtask : pulse_cmd

  // Read data watcher
  always @(posedge clk) rd_taken <= reg_rd;
  always @(negedge clk) begin
    if (rd_taken && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (e[15:8] != 8'h0)
        chk("reg_rdata", {2'h0, e[7:0]}, {2'h0, rdata & e[15:8]});
    end
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      summarize();
    end
  end

  //////////////////////////////////////////////////////////////////////
  initial begin
    do_reset();
    rd(8'h1a, 8'hff, 8'h0f);
    rd(8'h1b, 8'hff, 8'h00);
    rd(8'h1c, 8'hff, 8'h60);
    rd(8'h1d, 8'hff, 8'h00);
    chk1("phy_power_down", 1'b1, pd);
    chk1("alarm_hi", 1'b0, ahi);
    chk("vbus_voltage", 10'h0, vvolt);
    wr(8'h1a, 8'hff);
    rd(8'h1a, 8'hff, 8'h7f);
    chk1("phy_power_down", 1'b0, pd);
    wr(8'h1b, 8'hff);
    rd(8'h1b, 8'hff, 8'h09);
    chk1("discharge_timer_en", 1'b0, tmr);
    chk1("overcurrent_en", 1'b0, ocp);
    wr(8'h1b, 8'h00);
    rd(8'h1d, 8'h00, 8'h00);
    chk1("discharge_timer_en", 1'b1, tmr);
    chk1("overcurrent_en", 1'b1, ocp);
    wr(8'h1d, 8'hff);
    rd(8'h1d, 8'hff, 8'h00);
    wr(8'h1e, 8'h5a);
    rd(8'h1e, 8'hff, 8'h00);
    // Every termination code on both pins, fixed roles
    for (int i = 0; i < 16; i++) begin
      v = {2'h0, 2'($random(seed)), 4'(i)};
      wr(8'h1a, v);
      rd(8'h1a, 8'hff, v);
      chk("cc1_termination", {8'h0, v[1:0]}, {8'h0, t1});
      chk("cc2_termination", {8'h0, v[3:2]}, {8'h0, t2});
      chk("pullup_level", {8'h0, v[5:4]}, {8'h0, rpl});
      chk1("phy_power_down", v[3:0] == 4'hf, pd);
    end
    // Power controls with a source request pending
    @(posedge clk);
    src_req <= 1'b1;
    vlevel <= 10'($random(seed));
    wr(8'h1c, 8'hff);
    rd(8'h1c, 8'hff, 8'h7f);
    chk1("bleed", 1'b1, bleed);
    chk1("discharge_en", 1'b1, dis_en);
    chk1("source_en", 1'b0, src_en);
    chk1("vconn_cc2_en", 1'b1, vc2);
    chk1("vconn_cc1_en", 1'b0, vc1);
    chk("vbus_voltage", 10'h0, vvolt);
    @(posedge clk);
    flip <= 1'b1;
    @(negedge clk);
    chk1("vconn_cc1_en", 1'b1, vc1);
    chk1("vconn_cc2_en", 1'b0, vc2);
    wr(8'h1c, 8'h02);
    repeat (6) @(negedge clk);
    chk1("vconn_cc1_en", 1'b0, vc1);
    chk1("discharge_en", 1'b0, dis_en);
    chk1("bleed", 1'b0, bleed);
    chk1("source_en", 1'b1, src_en);
    chk("vbus_voltage", vlevel, vvolt);
    chk1("alarm_hi", 1'b1, ahi);
    chk1("alarm_lo", 1'b0, alo);
    // Mixed terminations: search refused
    wr(8'h1a, 8'h46);
    pulse_cmd();
    rd(8'h1d, 8'h30, 8'h00);
    chk("cc1_termination", 10'h2, {8'h0, t1});
    // Rp/Rp search, sink partner arrives late
    wr(8'h1a, 8'h55);
    pulse_cmd();
    rd(8'h1d, 8'h20, 8'h20);
    chk("cc1_termination", 10'h1, {8'h0, t1});
    repeat (1260) @(negedge clk);
    chk("cc1_termination", 10'h2, {8'h0, t1});
    chk("cc2_termination", 10'h2, {8'h0, t2});
    chk("pullup_level", 10'h1, {8'h0, rpl});
    @(posedge clk);
    pmode <= 2'h1;
    for (int i = 0; i < 1000 && st[5]; i++) rd(8'h1d, 8'h00, 8'h00);
    chk1("search_flag", 1'b0, st[5]);
    rd(8'h1d, 8'h10, 8'h00);
    @(posedge clk);
    pmode <= 2'h2;
    repeat (1400) @(negedge clk);
    chk("cc1_termination", 10'h1, {8'h0, t1});
    chk("cc2_termination", 10'h1, {8'h0, t2});
    // Source detach with automatic discharge
    wr(8'h1c, 8'h10);
    @(negedge clk);
    chk1("source_en", 1'b1, src_en);
    @(posedge clk);
    pmode <= 2'h0;
    ts = -1;
    td = -1;
    for (int j = 0; j < 12; j++) begin
      @(negedge clk);
      if (!src_en && ts < 0) ts = j;
      if (dis_en && td < 0) td = j;
    end
    chk1("source_off_first", ts >= 0 && ts < td, 1'b1);
    repeat (10) @(negedge clk);
    chk1("discharge_en", 1'b0, dis_en);
    chk1("discharge_failed", 1'b0, failed);
    // Sink detach, VBUS too slow: timer ends it
    @(posedge clk);
    src_req <= 1'b0;
    slow <= 1'b1;
    pmode <= 2'h2;
    wr(8'h1a, 8'h0a);
    @(posedge clk);
    pmode <= 2'h0;
    repeat (6) @(negedge clk);
    chk1("discharge_en", 1'b1, dis_en);
    repeat (60) @(negedge clk);
    chk1("discharge_en", 1'b0, dis_en);
    chk1("discharge_failed", 1'b1, failed);
    // Forced discharge: timer stops it, unless the timer is off
    wr(8'h1c, 8'h04);
    repeat (60) @(negedge clk);
    chk1("discharge_en", 1'b0, dis_en);
    wr(8'h1c, 8'h00);
    wr(8'h1b, 8'h08);
    wr(8'h1c, 8'h04);
    repeat (60) @(negedge clk);
    chk1("discharge_en", 1'b1, dis_en);
    wr(8'h1c, 8'h00);
    wr(8'h1b, 8'h00);
    // Rd/Rd search, source partner already present
    @(posedge clk);
    pmode <= 2'h2;
    wr(8'h1a, 8'h4a);
    pulse_cmd();
    repeat (10) @(negedge clk);
    rd(8'h1d, 8'h3f, 8'h11);
    chk("cc1_termination", 10'h2, {8'h0, t1});
    // Reset with supply present
    @(posedge clk);
    vdd <= 1'b1;
    do_reset();
    rd(8'h1a, 8'hff, 8'h05);
    summarize();
  end
endmodule : ccp_ctrl_tb_top
`default_nettype wire
